//--- pkg/adcm_pkg.sv
// adcm_pkg: constants and types of the alarm delay and contact mode block
// assumes one 200 MHz clock and byte addresses on the register port
package adcm_pkg;
  // clock and second tick
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned SEC_CYCLES_DFLT = TICK_S * CLK_HZ;
  // delay settings, minutes.seconds
  localparam logic [5:0] SEC_MAX = 6'h3B;
  localparam logic [6:0] MIN_MAX = 7'h63;
  localparam int unsigned N_CHAN = 8;
  localparam logic [3:0] GRP_MAX = 4'h8;
  localparam logic [3:0] GRP_RST = 4'h4;
  // contact internal relay numbers
  localparam logic [12:0] RLY_ONE = 13'h13A1;
  localparam logic [12:0] RLY_TWO = 13'h13A2;
  localparam logic [12:0] RLY_THREE = 13'h13A3;
  localparam logic [12:0] RLY_SIXTEEN = 13'h13B6;
  // contact functions, one assignment register each
  localparam int unsigned FN_AM = 0;
  localparam int unsigned FN_RL = 1;
  localparam int unsigned FN_SR = 2;
  localparam int unsigned FN_CAS = 3;
  localparam int unsigned FN_AUTO = 4;
  localparam int unsigned FN_MAN = 5;
  localparam int unsigned FN_REM = 6;
  localparam int unsigned FN_N = 7;
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_FN_BASE = 8'h20;
  localparam logic [7:0] OFF_DLY_BASE = 8'h40;
  localparam logic [7:0] BLK_MASK = 8'hE3;
  // control register fields
  localparam int unsigned CT_GRP = 0;
  localparam int unsigned CT_GATE = 4;
  localparam int unsigned CT_CTLM = 6;
  localparam int unsigned CT_RALM = 8;
  localparam int unsigned CT_RSRC = 9;
  localparam int unsigned CT_RPOL = 12;
  localparam int unsigned CT_LP2 = 13;
  localparam int unsigned CT_CTYPE = 16;
  // delay register fields
  localparam int unsigned DL_ONS = 0;
  localparam int unsigned DL_ONM = 8;
  localparam int unsigned DL_OFS = 16;
  localparam int unsigned DL_OFM = 24;
  // alarm gating modes
  localparam logic [1:0] GATE_ALWAYS = 2'h0;
  localparam logic [1:0] GATE_NO_STOP = 2'h1;
  localparam logic [1:0] GATE_NO_STOP_MAN = 2'h2;
  typedef enum logic [1:0] {OPM_MAN, OPM_AUTO, OPM_CAS} adcm_opm_t;
  typedef enum logic [1:0] {CTL_SINGLE, CTL_CASCADE, CTL_CAS_SECOND}
    adcm_ctl_t;
  typedef enum logic {CH_IDLE, CH_ACTIVE} adcm_ch_t;
endpackage

//--- logic/adcm_top.sv
// adcm_top: alarm on/off delay channels, relay polarity, mode gating,
// contact input functions mapped onto the operation mode
// assumes contact inputs may be asynchronous; registers on a plain port
// How it works
// - alarm rises only after its condition held for the on-delay.
// - condition lost during on-delay clears the timer, no alarm.
// - after condition clears, alarm stays on for the off-delay.
// - condition back during off-delay resets timer, alarm stays.
// - eight channels, own on and off delays, up to 99:59.
// - control relay carries an alarm when not doing control duty.
// - relay polarity 0 closes on event, 1 opens on event.
// - gating 0 always, 1 off in STOP, 2 off in STOP or MAN.
// - an input already on at power-up counts as rising.
// - inputs are picked by relay numbers 5025-5027 and 5046.
// - energized contact type runs a function while contact is on.
// - auto/manual level: on AUTO and locked, off MAN and free.
// - auto/manual level ignored in either cascade control mode.
// - remote/local level: on REMOTE and locked, off LOCAL.
// - stop/run level sets STOP/RUN, locks while assigned.
// - cascade request rising edge in cascade control selects CAS.
// - auto request rising edge in cascade control selects AUTO.
// - manual request rising edge selects MAN.
// - far setpoint request rising edge selects REMOTE.
// - loop-two lamp lit in cascade while loop two is shown.
// - group count 0 to 8; unused channels and timers stop.
`timescale 1ns/1ps
`default_nettype none

module adcm_chan
  import adcm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic tick_i,
  input wire logic en_i,
  input wire logic cond_i,
  input wire logic [6:0] on_min_i,
  input wire logic [5:0] on_sec_i,
  input wire logic [6:0] off_min_i,
  input wire logic [5:0] off_sec_i,
  output logic out_o
);
  adcm_ch_t st_reg, st_next;
  logic [6:0] min_reg, min_next;
  logic [5:0] sec_reg, sec_next;
  wire sec_wrap = (sec_reg == SEC_MAX);
  wire [5:0] sec_inc = sec_wrap ? 6'h00 : 6'(sec_reg + 6'h01);
  wire [6:0] min_inc = sec_wrap ? 7'(min_reg + 7'h01) : min_reg;
  wire on_done = (min_reg == on_min_i) && (sec_reg == on_sec_i);
  wire off_done = (min_reg == off_min_i) && (sec_reg == off_sec_i);
  always_comb begin
    st_next = st_reg;
    sec_next = sec_reg;
    min_next = min_reg;
    case (st_reg)
      CH_IDLE: begin
        if (!cond_i) begin
          sec_next = 6'h00;
          min_next = 7'h00;
        end else if (on_done) begin
          st_next = CH_ACTIVE;
          sec_next = 6'h00;
          min_next = 7'h00;
        end else if (tick_i) begin
          sec_next = sec_inc;
          min_next = min_inc;
        end
      end
      CH_ACTIVE: begin
        if (cond_i) begin
          sec_next = 6'h00;
          min_next = 7'h00;
        end else if (off_done) begin
          st_next = CH_IDLE;
          sec_next = 6'h00;
          min_next = 7'h00;
        end else if (tick_i) begin
          sec_next = sec_inc;
          min_next = min_inc;
        end
      end
      default: st_next = CH_IDLE;
    endcase
    if (!en_i) begin
      st_next = CH_IDLE;
      sec_next = 6'h00;
      min_next = 7'h00;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= CH_IDLE;
      sec_reg <= 6'h00;
      min_reg <= 7'h00;
      out_o <= 1'b0;
    end else begin
      st_reg <= st_next;
      sec_reg <= sec_next;
      min_reg <= min_next;
      out_o <= (st_next == CH_ACTIVE);
    end
  end
  on_delay_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(out_o) |-> $past(cond_i) && $past(on_done) && $past(en_i))
    else $error("alarm rose without its on-delay completing");
  on_abort_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (st_reg == CH_IDLE) && !cond_i |=> sec_reg == 6'h00 && min_reg == 7'h00
      && !out_o)
    else $error("on-delay timer not cleared when condition left");
  off_delay_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $fell(out_o) |-> !$past(en_i) || (!$past(cond_i) && $past(off_done)))
    else $error("alarm fell before its off-delay completed");
  off_restart_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    out_o && cond_i && en_i |=> out_o && sec_reg == 6'h00)
    else $error("returning condition did not hold the alarm");
  unused_chan_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !en_i |=> !out_o && min_reg == 7'h00)
    else $error("disabled channel still active");
  sec_range_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sec_reg == SEC_MAX && tick_i && st_next == st_reg && min_next != 7'h00
      |=> sec_reg == 6'h00)
    else $error("seconds did not roll over at 59");
endmodule
module adcm_top
  import adcm_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SEC_CYCLES_DFLT
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [7:0] alarm_cond_i,
  input wire logic input_contact_one_i,
  input wire logic input_contact_two_i,
  input wire logic input_contact_three_i,
  input wire logic input_contact_sixteen_i,
  input wire logic ctrl_out_i,
  output logic [7:0] alarm_o,
  output logic relay_o,
  output logic [1:0] op_mode_o,
  output logic remote_o,
  output logic stop_o,
  output logic am_lock_o,
  output logic rl_lock_o,
  output logic sr_lock_o,
  output logic loop_two_indicator_o
);
  // control settings
  logic [3:0] grp_reg;
  logic [1:0] gate_reg;
  logic [1:0] ctlm_reg;
  logic ralm_reg;
  logic [2:0] rsrc_reg;
  logic rpol_reg;
  logic lp2_reg;
  logic [3:0] ctype_reg;
  logic [12:0] fn_reg [FN_N];
  logic [6:0] onm_reg [N_CHAN];
  logic [5:0] ons_reg [N_CHAN];
  logic [6:0] ofm_reg [N_CHAN];
  logic [5:0] ofs_reg [N_CHAN];
  // mode state
  adcm_opm_t opm_reg, opm_next;
  logic remote_next, stop_next;
  // contacts
  logic [3:0] sync1_reg, sync2_reg, prev_reg;
  logic [31:0] div_reg;
  logic tick_reg;
  logic [31:0] rd_next;
  // second tick; shorten SEC_CYCLES in simulation
  wire div_end = (div_reg == 32'(SEC_CYCLES - 1));
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_reg <= 32'h0;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_end ? 32'h0 : 32'(div_reg + 32'h1);
      tick_reg <= div_end;
    end
  end
  // prev starts at off, so a contact on at power-up reads as a rise
  wire [3:0] raw = {input_contact_sixteen_i, input_contact_three_i,
                    input_contact_two_i, input_contact_one_i};
  wire [3:0] lvl = sync2_reg ^ ctype_reg;
  wire [3:0] rise = lvl & ~prev_reg;
  wire [3:0] fall = ~lvl & prev_reg;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      prev_reg <= 4'h0;
    end else begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
      prev_reg <= lvl;
    end
  end
  logic [FN_N-1:0] fn_ok, fn_lvl, fn_rise, fn_fall;
  for (genvar f = 0; f < FN_N; f++) begin : g_fn
    wire [3:0] m = {fn_reg[f] == RLY_SIXTEEN, fn_reg[f] == RLY_THREE,
                    fn_reg[f] == RLY_TWO, fn_reg[f] == RLY_ONE};
    assign fn_ok[f] = |m;
    assign fn_lvl[f] = |(m & lvl);
    assign fn_rise[f] = |(m & rise);
    assign fn_fall[f] = |(m & fall);
  end
  // register decode
  wire wr_ctrl = reg_we_i && (reg_addr_i == OFF_CTRL);
  wire wr_mode = reg_we_i && (reg_addr_i == OFF_MODE);
  wire fn_blk = ((reg_addr_i & BLK_MASK) == OFF_FN_BASE);
  wire dly_blk = ((reg_addr_i & BLK_MASK) == OFF_DLY_BASE);
  wire [2:0] idx = reg_addr_i[4:2];
  wire fn_hit = fn_blk && (32'(idx) < FN_N);
  wire [3:0] grp_w = reg_wdata_i[CT_GRP+:4];
  wire [1:0] gate_w = reg_wdata_i[CT_GATE+:2];
  wire [1:0] ctlm_w = reg_wdata_i[CT_CTLM+:2];
  // mode control; contact levels outrank edges, edges outrank software
  wire is_cas = (ctlm_reg == CTL_CASCADE);
  wire any_cas = is_cas || (ctlm_reg == CTL_CAS_SECOND);
  wire am_act = fn_ok[FN_AM] && !any_cas;
  wire am_lock = am_act && fn_lvl[FN_AM];
  wire rl_lock = fn_ok[FN_RL] && fn_lvl[FN_RL];
  wire sr_act = fn_ok[FN_SR];
  wire [1:0] opm_w = reg_wdata_i[1:0];
  wire sw_opm = wr_mode && !am_lock && (opm_w != 2'h3);
  always_comb begin
    opm_next = opm_reg;
    if (am_lock)
      opm_next = OPM_AUTO;
    else if (am_act && fn_fall[FN_AM])
      opm_next = OPM_MAN;
    else if (fn_ok[FN_MAN] && fn_rise[FN_MAN])
      opm_next = OPM_MAN;
    else if (is_cas && fn_ok[FN_AUTO] && fn_rise[FN_AUTO])
      opm_next = OPM_AUTO;
    else if (is_cas && fn_ok[FN_CAS] && fn_rise[FN_CAS])
      opm_next = OPM_CAS;
    else if (sw_opm)
      opm_next = adcm_opm_t'(opm_w);
  end
  assign remote_next = rl_lock ? 1'b1 :
    (fn_ok[FN_RL] && fn_fall[FN_RL]) ? 1'b0 :
    (fn_ok[FN_REM] && fn_rise[FN_REM]) ? 1'b1 :
    wr_mode ? reg_wdata_i[2] : remote_o;
  assign stop_next = sr_act ? fn_lvl[FN_SR] :
    wr_mode ? reg_wdata_i[3] : stop_o;
  // alarm gating and channels
  wire is_man = (opm_reg == OPM_MAN);
  wire gate_ok = (gate_reg == GATE_ALWAYS) ||
    ((gate_reg == GATE_NO_STOP) && !stop_o) ||
    ((gate_reg == GATE_NO_STOP_MAN) && !stop_o && !is_man);
  for (genvar k = 0; k < N_CHAN; k++) begin : g_ch
    wire ch_en = (k < grp_reg) && gate_ok;
    adcm_chan u_chan (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .tick_i(tick_reg),
      .en_i(ch_en),
      .cond_i(alarm_cond_i[k]),
      .on_min_i(onm_reg[k]),
      .on_sec_i(ons_reg[k]),
      .off_min_i(ofm_reg[k]),
      .off_sec_i(ofs_reg[k]),
      .out_o(alarm_o[k])
    );
  end
  // control relay terminal
  wire evt = alarm_o[rsrc_reg];
  wire relay_next = ralm_reg ? (evt ^ rpol_reg) : ctrl_out_i;
  // out-of-range delays and group counts are clamped; out-of-range gating and control modes are refused
  function automatic logic [5:0] clamp_sec(input logic [7:0] v);
    clamp_sec = (v > 8'(SEC_MAX)) ? SEC_MAX : v[5:0];
  endfunction
  function automatic logic [6:0] clamp_min(input logic [7:0] v);
    clamp_min = (v > 8'(MIN_MAX)) ? MIN_MAX : v[6:0];
  endfunction
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      grp_reg <= GRP_RST;
      gate_reg <= GATE_ALWAYS;
      ctlm_reg <= CTL_SINGLE;
      ralm_reg <= 1'b0;
      rsrc_reg <= 3'h0;
      rpol_reg <= 1'b0;
      lp2_reg <= 1'b0;
      ctype_reg <= 4'h0;
      for (int i = 0; i < FN_N; i++)
        fn_reg[i] <= 13'h0000;
      for (int i = 0; i < N_CHAN; i++) begin
        onm_reg[i] <= 7'h00;
        ons_reg[i] <= 6'h00;
        ofm_reg[i] <= 7'h00;
        ofs_reg[i] <= 6'h00;
      end
    end else begin
      if (wr_ctrl) begin
        grp_reg <= (grp_w > GRP_MAX) ? GRP_MAX : grp_w;
        gate_reg <= (gate_w > GATE_NO_STOP_MAN) ? gate_reg : gate_w;
        ctlm_reg <= (ctlm_w > CTL_CAS_SECOND) ? ctlm_reg : ctlm_w;
        ralm_reg <= reg_wdata_i[CT_RALM];
        rsrc_reg <= reg_wdata_i[CT_RSRC+:3];
        rpol_reg <= reg_wdata_i[CT_RPOL];
        lp2_reg <= reg_wdata_i[CT_LP2];
        ctype_reg <= reg_wdata_i[CT_CTYPE+:4];
      end
      if (reg_we_i && fn_hit)
        fn_reg[idx] <= reg_wdata_i[12:0];
      if (reg_we_i && dly_blk) begin
        ons_reg[idx] <= clamp_sec(reg_wdata_i[DL_ONS+:8]);
        onm_reg[idx] <= clamp_min(reg_wdata_i[DL_ONM+:8]);
        ofs_reg[idx] <= clamp_sec(reg_wdata_i[DL_OFS+:8]);
        ofm_reg[idx] <= clamp_min(reg_wdata_i[DL_OFM+:8]);
      end
    end
  end

  always_comb begin
    rd_next = 32'h0;
    if (reg_addr_i == OFF_CTRL) begin
      rd_next[CT_GRP+:4] = grp_reg;
      rd_next[CT_GATE+:2] = gate_reg;
      rd_next[CT_CTLM+:2] = ctlm_reg;
      rd_next[CT_RALM] = ralm_reg;
      rd_next[CT_RSRC+:3] = rsrc_reg;
      rd_next[CT_RPOL] = rpol_reg;
      rd_next[CT_LP2] = lp2_reg;
      rd_next[CT_CTYPE+:4] = ctype_reg;
    end else if (reg_addr_i == OFF_MODE) begin
      rd_next[6:0] = {sr_lock_o, rl_lock_o, am_lock_o, stop_o, remote_o,
                      op_mode_o};
    end else if (reg_addr_i == OFF_STAT) begin
      rd_next[12:0] = {relay_o, lvl, alarm_o};
    end else if (fn_hit) begin
      rd_next[12:0] = fn_reg[idx];
    end else if (dly_blk) begin
      rd_next[DL_ONS+:6] = ons_reg[idx];
      rd_next[DL_ONM+:7] = onm_reg[idx];
      rd_next[DL_OFS+:6] = ofs_reg[idx];
      rd_next[DL_OFM+:7] = ofm_reg[idx];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 32'h0;
      opm_reg <= OPM_MAN;
      op_mode_o <= 2'h0;
      remote_o <= 1'b0;
      stop_o <= 1'b0;
      am_lock_o <= 1'b0;
      rl_lock_o <= 1'b0;
      sr_lock_o <= 1'b0;
      relay_o <= 1'b0;
      loop_two_indicator_o <= 1'b0;
    end else begin
      reg_rdata_o <= reg_re_i ? rd_next : 32'h0;
      opm_reg <= opm_next;
      op_mode_o <= opm_next;
      remote_o <= remote_next;
      stop_o <= stop_next;
      am_lock_o <= am_lock;
      rl_lock_o <= rl_lock;
      sr_lock_o <= sr_act;
      relay_o <= relay_next;
      loop_two_indicator_o <= is_cas && lp2_reg;
    end
  end
  am_level_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    am_act && fn_lvl[FN_AM] |=> op_mode_o == OPM_AUTO && am_lock_o)
    else $error("auto/manual contact on did not force AUTO");
  am_cascade_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    any_cas |=> !am_lock_o)
    else $error("auto/manual contact acted in cascade control");
  man_edge_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    fn_ok[FN_MAN] && fn_rise[FN_MAN] && !am_act |=> op_mode_o == OPM_MAN)
    else $error("manual request edge did not select MAN");
  far_sp_edge_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    fn_ok[FN_REM] && fn_rise[FN_REM] && !fn_ok[FN_RL] |=> remote_o)
    else $error("far setpoint edge did not select REMOTE");
  stop_level_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sr_act |=> stop_o == $past(fn_lvl[FN_SR]) && sr_lock_o)
    else $error("stop/run contact not followed");
  relay_pol_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ralm_reg |=> relay_o == ($past(evt) ^ $past(rpol_reg)))
    else $error("relay contact polarity wrong");
  stop_gate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    gate_reg != GATE_ALWAYS && stop_o ##1 gate_reg != GATE_ALWAYS && stop_o
      |=> alarm_o == 8'h00)
    else $error("alarm active while gated off in STOP");
  pwrup_rise_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(rstn_i) ##2 lvl[0] |-> rise[0])
    else $error("contact on at power-up not seen as rising");
endmodule
`default_nettype wire

//--- dv/adcm_field_model.sv
// adcm_field_model: field side of the block, switch contacts and relay
// assumes the bench commands contact levels; contacts move on a clock edge
`timescale 1ns/1ps
`default_nettype none
module adcm_field_model (
  input wire logic clk_i,
  input wire logic [3:0] sw_cmd_i,
  input wire logic relay_i,
  output logic [3:0] contact_o,
  output logic relay_closed_o
);
  // energized contacts: on means closed switch; no bounce is modelled
  initial contact_o = 4'h0;
  always @(posedge clk_i) contact_o <= sw_cmd_i;
  assign relay_closed_o = relay_i;
endmodule
`default_nettype wire

//--- dv/alarm_delay_and_contact_mode_logic_tb.sv
// alarm_delay_and_contact_mode_logic_tb: self-checking bench for adcm_top
// assumes SEC_CYCLES cut to 4 clocks so that one second is short
`timescale 1ns/1ps
`default_nettype none
module alarm_delay_and_contact_mode_logic_tb;
  import adcm_pkg::*;
  localparam int unsigned SC = 4;
  typedef struct {string nm; logic [31:0] e; logic [31:0] m;} adcm_note_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic re_d = 1'b0;
  logic [31:0] rdata;
  logic [7:0] cond = 8'h00;
  logic [3:0] sw = 4'h0;
  logic [3:0] contact;
  logic ctrl_out = 1'b0;
  logic [7:0] alarm;
  logic [1:0] op_mode;
  logic relay, relay_closed, remote, stop, am_lk, rl_lk, sr_lk, lp2;
  int err_count = 0;
  int tests_run = 0;
  adcm_note_t notes[$];
  always #2.5 clk = ~clk;
  adcm_top #(.SEC_CYCLES(SC)) uut (.clk_i(clk), .rstn_i(rstn),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .alarm_cond_i(cond),
    .input_contact_one_i(contact[0]), .input_contact_two_i(contact[1]),
    .input_contact_three_i(contact[2]),
    .input_contact_sixteen_i(contact[3]), .ctrl_out_i(ctrl_out),
    .alarm_o(alarm), .relay_o(relay), .op_mode_o(op_mode),
    .remote_o(remote), .stop_o(stop), .am_lock_o(am_lk),
    .rl_lock_o(rl_lk), .sr_lock_o(sr_lk), .loop_two_indicator_o(lp2));
  adcm_field_model field (.clk_i(clk), .sw_cmd_i(sw), .relay_i(relay),
    .contact_o(contact), .relay_closed_o(relay_closed));
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      err_count++;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  // the expectation is queued first; the watcher pops it when data lands
  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e, input logic [31:0] m);
    adcm_note_t n;
    n.nm = nm;
    n.e = e;
    n.m = m;
    @(posedge clk);
    notes.push_back(n);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // two sync flops, compare and output register, plus the model's edge
  task automatic contacts(input logic [3:0] v);
    @(posedge clk);
    sw <= v;
    idle(6);
  endtask
  task automatic wait_alarm(input int ch, input logic lvl, input int bound);
    for (int i = 0; i < bound && alarm[ch] !== lvl; i++) @(posedge clk);
    if (alarm[ch] !== lvl) begin
      chk("alarm wait", {31'h0, alarm[ch]}, {31'h0, lvl});
      report_and_stop();
    end
  endtask
  always @(posedge clk) re_d <= re;
  always @(negedge clk) begin
    adcm_note_t n;
    if (re_d) begin
      if (notes.size() == 0) begin
        chk("unexpected read", 32'h1, 32'h0);
      end else begin
        n = notes.pop_front();
        chk(n.nm, rdata & n.m, n.e & n.m);
      end
    end else if (rstn) begin
      chk("idle read data", rdata, 32'h0);
    end
  end
  initial begin
    int on_s;
    static logic [1:0] gt[6] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2};
    static logic [3:0] md[6] = '{4'h0, 4'h0, 4'h0, 4'h9, 4'h9, 4'h1};
    static logic [7:0] ge[6] = '{8'h02, 8'h02, 8'h00, 8'h02, 8'h00, 8'h02};
    static int eb[4] = '{0, 1, 3, 2};
    static logic [2:0] em[4] = '{3'h2, 3'h1, 3'h5, 3'h4};
    void'($urandom(47));
    on_s = $urandom_range(3, 2);
    idle(3);
    rstn <= 1'b1;
    rd("ctrl reset", OFF_CTRL, 32'h4, 32'hFFFFFFFF);
    rd("mode reset", OFF_MODE, 32'h0, 32'hFFFFFFFF);
    rd("unmapped read", 8'hFC, 32'h0, 32'hFFFFFFFF);
    wr(OFF_DLY_BASE + 8'h1C, 32'h7F3F7F3F);
    rd("delay clamp", OFF_DLY_BASE + 8'h1C, 32'h633B633B, 32'h7F3F7F3F);
    // group count: channels at and above the count stay silent
    cond <= 8'hFF;
    idle(4);
    rd("four groups", OFF_STAT, 32'h0F, 32'hFF);
    wr(OFF_CTRL, 32'h9);
    rd("group clamp", OFF_CTRL, 32'h8, 32'hF);
    // channel 7 still waits out its 99:59 on-delay
    rd("eight groups", OFF_STAT, 32'h7F, 32'hFF);
    wr(OFF_CTRL, 32'h0);
    idle(3);
    rd("no groups", OFF_STAT, 32'h00, 32'hFF);
    cond <= 8'h02;
    for (int i = 0; i < 6; i++) begin
      wr(OFF_MODE, {28'h0, md[i]});
      wr(OFF_CTRL, 32'h8 | ({30'h0, gt[i]} << CT_GATE));
      idle(4);
      rd("gated alarm", OFF_STAT, {24'h0, ge[i]}, 32'hFF);
    end
    wr(OFF_MODE, 32'h0);
    wr(OFF_CTRL, 32'h8);
    ctrl_out <= 1'b1;
    idle(3);
    rd("relay control", OFF_STAT, 32'h1000, 32'h1000);
    ctrl_out <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      wr(OFF_CTRL, 32'h308 | (p << CT_RPOL));
      for (int c = 0; c < 2; c++) begin
        cond <= {6'h0, c[0], 1'b0};
        idle(5);
        chk("relay contact", {31'h0, relay_closed}, c ^ p);
      end
    end
    wr(OFF_CTRL, 32'h8);
    cond <= 8'h00;
    wr(OFF_DLY_BASE, 32'h00020000 | on_s);
    // a pulse shorter than the on-delay must leave no trace
    cond <= 8'h01;
    idle(3);
    cond <= 8'h00;
    idle(20);
    chk("short pulse", {31'h0, alarm[0]}, 32'h0);
    cond <= 8'h01;
    idle(3);
    chk("on delay early", {31'h0, alarm[0]}, 32'h0);
    wait_alarm(0, 1'b1, 4 * on_s + 6);
    cond <= 8'h00;
    idle(2);
    cond <= 8'h01;
    idle(20);
    chk("off delay restart", {31'h0, alarm[0]}, 32'h1);
    cond <= 8'h00;
    idle(3);
    chk("off delay hold", {31'h0, alarm[0]}, 32'h1);
    wait_alarm(0, 1'b0, 14);
    // an on-delay of 1:01 needs the seconds to roll into the minutes
    wr(OFF_DLY_BASE + 8'h08, 32'h00000101);
    cond <= 8'h04;
    idle(230);
    chk("minute early", {31'h0, alarm[2]}, 32'h0);
    wait_alarm(2, 1'b1, 18);
    cond <= 8'h00;
    wr(OFF_FN_BASE, {19'h0, RLY_ONE});
    wr(OFF_FN_BASE + 8'h04, {19'h0, RLY_TWO});
    wr(OFF_FN_BASE + 8'h08, {19'h0, RLY_THREE});
    contacts(4'h7);
    rd("levels on", OFF_MODE, 32'h7D, 32'h7F);
    rd("contact status", OFF_STAT, 32'h700, 32'hF00);
    wr(OFF_MODE, 32'h0);
    rd("locked mode", OFF_MODE, 32'h7D, 32'h7F);
    contacts(4'h0);
    rd("levels off", OFF_MODE, 32'h40, 32'h7F);
    wr(OFF_CTRL, 32'h48);
    contacts(4'h1);
    rd("auto level in cascade", OFF_MODE, 32'h0, 32'h3);
    contacts(4'h0);
    for (int f = 0; f < 3; f++) wr(OFF_FN_BASE + 8'(4 * f), 32'h0);
    wr(OFF_FN_BASE + 8'h0C, {19'h0, RLY_ONE});
    wr(OFF_FN_BASE + 8'h10, {19'h0, RLY_TWO});
    wr(OFF_FN_BASE + 8'h14, {19'h0, RLY_THREE});
    wr(OFF_FN_BASE + 8'h18, {19'h0, RLY_SIXTEEN});
    for (int k = 0; k < 4; k++) begin
      contacts(4'h1 << eb[k]);
      rd("rising edge", OFF_MODE, {29'h0, em[k]}, 32'h7);
      contacts(4'h0);
      rd("falling edge", OFF_MODE, {29'h0, em[k]}, 32'h7);
    end
    wr(OFF_CTRL, 32'h8);
    contacts(4'h1);
    rd("cascade edge single", OFF_MODE, 32'h4, 32'h7);
    contacts(4'h0);
    wr(OFF_CTRL, 32'h2048);
    idle(2);
    chk("loop two lamp", {31'h0, lp2}, 32'h1);
    wr(OFF_CTRL, 32'h2008);
    idle(2);
    chk("loop two single", {31'h0, lp2}, 32'h0);
    // contact one held on through a reset must read as a fresh rise
    contacts(4'h1);
    rstn <= 1'b0;
    idle(3);
    rstn <= 1'b1;
    wr(OFF_FN_BASE + 8'h18, {19'h0, RLY_ONE});
    idle(2);
    rd("rise at power-up", OFF_MODE, 32'h4, 32'h7);
    rd("ctrl after reset", OFF_CTRL, 32'h4, 32'hFFFFFFFF);
    idle(2);
    report_and_stop();
  end
endmodule
`default_nettype wire
